// ### rtl/vcc_pkg.sv
`default_nettype none
package vcc_pkg;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned CB_DELAY_MS = 100;
  localparam int unsigned CB_CYC      = CB_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned PWM_HZ      = 1000;
  localparam int unsigned PWM_CYC     = CLK_HZ / PWM_HZ;
  localparam int unsigned CBW         = 24;
  localparam int unsigned PW          = 16;

  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FILT  = 8'h04;
  localparam logic [7:0] OFS_CBCMD = 8'h08;
  localparam logic [7:0] OFS_CBFB  = 8'h0C;
  localparam logic [7:0] OFS_PRED  = 8'h10;
  localparam logic [7:0] OFS_DITH  = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_CMD   = 8'h1C;

  localparam int P_EN   = 0;
  localparam int P_MODE = 1;
  localparam int P_STD2 = 3;
  localparam int P_CBEN = 4;
  localparam int P_MEAS = 5;
  localparam int P_SWS  = 6;
  localparam int P_PREN = 7;
  localparam int P_ACT  = 8;
  localparam int P_SIG  = 9;
  localparam int P_LO   = 0;
  localparam int P_HI   = 16;
  localparam int P_RPCT = 16;
  localparam int P_DHLF = 8;

  localparam logic [3:0] FILT_RST = 4'h4;
  localparam logic [6:0] RPCT_RST = 7'h32;
  localparam logic [7:0] DAMP_RST = 8'h10;
  localparam logic [7:0] DHLF_RST = 8'h05;
  localparam logic [9:0] FULL     = 10'h3FF;
  localparam logic [2:0] SIG_MAXCB = 3'h3;

  typedef enum logic [1:0] {CH_DIS = 2'b01, CH_ACT = 2'b10} vcc_chan_e;
  typedef enum logic [1:0] {
    M_UNI1 = 2'h0, M_UNI2 = 2'h1, M_BIP = 2'h2, M_DIG = 2'h3
  } vcc_mode_e;
endpackage
`default_nettype wire

// ### rtl/vcc_top.sv
// Summary of operation
// - Each input smoothed; bigger factor, slower response
// - Cable check only for analog-like signal types
// - Break when value below low or above high
// - Separate break errors for command and feedback
// - Check needs enable on and its own limits set (command or feedback)
// - Reaction only when action assigned to error
// - Break flagged about 100 ms after fault
// - Solenoid driven by 1 kHz PWM; dither added except for switching solenoid or zero command
// - Setting switches current measurement on/off
// - Four operating modes held per channel
// - Mode 1 linear, only with two-solenoid valve
// - Mode 2 unipolar input to bipolar command
// - Mode 3 bipolar input to bipolar command
// - Mode 4 sign chosen by digital input
// - Power reduction only for unmeasured switching solenoid
// - Full current for reduction time, then limited
// - Reduced value is percent of nominal current
// - Digital input 1 ignored while USB busy
// - Disabled: no current, mode changes accepted
`timescale 1ns/1ns
`default_nettype none
module vcc_top #(
  parameter int unsigned CB_CYCLES  = vcc_pkg::CB_CYC,
  parameter int unsigned PWM_CYCLES = vcc_pkg::PWM_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic             avs_waitrequest,
  output logic [31:0]      avs_readdata,
  input  wire logic        sample_vld,
  input  wire logic [9:0]  ain_cmd,
  input  wire logic [9:0]  ain_fb,
  input  wire logic        din1,
  input  wire logic        usb_busy,
  output logic             pwm_a,
  output logic             pwm_b,
  output logic             meas_en,
  output logic             cmd_fault,
  output logic             fb_fault,
  output logic             fault_react,
  output logic             chan_active,
  output logic [10:0]      cmd_int
);
  localparam int unsigned CBW = vcc_pkg::CBW;
  localparam int unsigned PW  = vcc_pkg::PW;

  if (CB_CYCLES < 2 || CB_CYCLES >= 2**CBW) begin : g_chk_cb
    $error("CB_CYCLES out of range");
  end
  if (PWM_CYCLES < 1024 || PWM_CYCLES >= 2**PW) begin : g_chk_pwm
    $error("PWM_CYCLES out of range");
  end

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
    vcc_pkg::vcc_chan_e  chan;
    vcc_pkg::vcc_mode_e  mode;
    logic                std2;
    logic                cben;
    logic                meas;
    logic                sws;
    logic                pren;
    logic                act;
    logic [2:0]          sig;
    logic [3:0]          k;
    logic [9:0]          clo;
    logic [9:0]          chi;
    logic [9:0]          flo;
    logic [9:0]          fhi;
    logic                cset;
    logic                fset;
    logic [15:0]         rms;
    logic [6:0]          rpct;
    logic [7:0]          damp;
    logic [7:0]          dhlf;
    logic [15:0]         fc;
    logic [15:0]         ff;
    logic [CBW-1:0]      cbc;
    logic [CBW-1:0]      cbf;
    logic                e1;
    logic                e6;
    logic [10:0]         cmd;
    logic [PW-1:0]       pcnt;
    logic [PW-1:0]       duty;
    logic                dirb;
    logic                pa;
    logic                pb;
    logic [7:0]          dcnt;
    logic                dph;
    logic [15:0]         rcnt;
    logic                red;
  } vcc_state_s;

  vcc_state_s s_q, s_d;

  logic [31:0] img, wmask, wv;
  logic        req, tick, cbok_c, cbok_f, brk_c, brk_f, react, pr_eff, neg;
  logic [9:0]  xc, xf, mag, base, rlim, lvl;
  logic [11:0] dith;
  logic [10:0] cmd_n;
  logic [16:0] dc, df;
  logic [25:0] prod;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign pwm_a           = s_q.pa;
  assign pwm_b           = s_q.pb;
  assign meas_en         = s_q.meas;
  assign cmd_fault       = s_q.e1;
  assign fb_fault        = s_q.e6;
  assign fault_react     = react;
  assign chan_active     = (s_q.chan == vcc_pkg::CH_ACT);
  assign cmd_int         = s_q.cmd;

  assign xc     = s_q.fc[15:6];
  assign xf     = s_q.ff[15:6];
  assign tick   = (s_q.pcnt == PW'(PWM_CYCLES - 1));
  assign react  = s_q.e1 & s_q.act;
  assign pr_eff = s_q.pren & s_q.sws & ~s_q.meas;
  assign cbok_c = s_q.cben & (s_q.sig <= vcc_pkg::SIG_MAXCB) & s_q.cset;
  assign cbok_f = s_q.cben & (s_q.sig <= vcc_pkg::SIG_MAXCB) & s_q.fset;
  assign brk_c  = (xc < s_q.clo) | (xc > s_q.chi);
  assign brk_f  = (xf < s_q.flo) | (xf > s_q.fhi);
  assign neg    = din1 & ~usb_busy;
  assign dc     = {1'b0, ain_cmd, 6'h00} - {1'b0, s_q.fc};
  assign df     = {1'b0, ain_fb, 6'h00} - {1'b0, s_q.ff};

  always_comb begin
    img = 32'h0000_0000;
    unique case (avs_address)
      vcc_pkg::OFS_CTRL: begin
        img[vcc_pkg::P_EN]          = (s_q.chan == vcc_pkg::CH_ACT);
        img[vcc_pkg::P_MODE +: 2]   = s_q.mode;
        img[vcc_pkg::P_STD2]        = s_q.std2;
        img[vcc_pkg::P_CBEN]        = s_q.cben;
        img[vcc_pkg::P_MEAS]        = s_q.meas;
        img[vcc_pkg::P_SWS]         = s_q.sws;
        img[vcc_pkg::P_PREN]        = s_q.pren;
        img[vcc_pkg::P_ACT]         = s_q.act;
        img[vcc_pkg::P_SIG +: 3]    = s_q.sig;
      end
      vcc_pkg::OFS_FILT:  img[3:0] = s_q.k;
      vcc_pkg::OFS_CBCMD: begin
        img[vcc_pkg::P_LO +: 10] = s_q.clo;
        img[vcc_pkg::P_HI +: 10] = s_q.chi;
      end
      vcc_pkg::OFS_CBFB: begin
        img[vcc_pkg::P_LO +: 10] = s_q.flo;
        img[vcc_pkg::P_HI +: 10] = s_q.fhi;
      end
      vcc_pkg::OFS_PRED: begin
        img[15:0]                  = s_q.rms;
        img[vcc_pkg::P_RPCT +: 7]  = s_q.rpct;
      end
      vcc_pkg::OFS_DITH: begin
        img[7:0]                   = s_q.damp;
        img[vcc_pkg::P_DHLF +: 8]  = s_q.dhlf;
      end
      vcc_pkg::OFS_STAT: img[5:0] = {s_q.red, s_q.cset & s_q.fset, chan_active,
                                     react, s_q.e6, s_q.e1};
      vcc_pkg::OFS_CMD:  img = {{21{s_q.cmd[10]}}, s_q.cmd};
      default:           img = 32'h0000_0000;
    endcase
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wv    = (img & ~wmask) | (avs_writedata & wmask);
  end

  // Command mapping, solenoid level, dither and power reduction
  always_comb begin
    unique case (s_q.mode)
      vcc_pkg::M_UNI1: cmd_n = {1'b0, xc};
      vcc_pkg::M_UNI2: cmd_n = {xc, 1'b0} - 11'h3FF;
      vcc_pkg::M_BIP:  cmd_n = (xc == 10'h200) ? 11'h401 : {xc, 1'b0};
      vcc_pkg::M_DIG:  cmd_n = neg ? -{1'b0, xc} : {1'b0, xc};
    endcase
    mag  = s_q.cmd[10] ? 10'(-s_q.cmd) : s_q.cmd[9:0];
    base = s_q.sws ? ((mag != 10'h000) ? vcc_pkg::FULL : 10'h000) : mag;
    dith = s_q.dph ? 12'(base) + 12'(s_q.damp) : 12'(base) - 12'(s_q.damp);
    if (base == 10'h000 || s_q.sws) begin
      lvl = base;
    end else if (dith[11]) begin
      lvl = 10'h000;
    end else if (dith[10]) begin
      lvl = vcc_pkg::FULL;
    end else begin
      lvl = dith[9:0];
    end
    rlim = 10'((17'(s_q.rpct) * 17'(vcc_pkg::FULL)) / 17'd100);
    if (pr_eff && s_q.red && lvl > rlim) begin
      lvl = rlim;
    end
    if (s_q.chan != vcc_pkg::CH_ACT || react) begin
      lvl = 10'h000;
    end
    prod = 26'(lvl) * 26'(PWM_CYCLES);
  end

  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    if (req && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_read) begin
        s_d.rdata = img;
      end
      if (avs_write) begin
        unique case (avs_address)
          vcc_pkg::OFS_CTRL: begin
            s_d.chan = wv[vcc_pkg::P_EN] ? vcc_pkg::CH_ACT : vcc_pkg::CH_DIS;
            s_d.std2 = wv[vcc_pkg::P_STD2];
            s_d.cben = wv[vcc_pkg::P_CBEN];
            s_d.meas = wv[vcc_pkg::P_MEAS];
            s_d.sws  = wv[vcc_pkg::P_SWS];
            s_d.act  = wv[vcc_pkg::P_ACT];
            s_d.sig  = wv[vcc_pkg::P_SIG +: 3];
            s_d.pren = wv[vcc_pkg::P_PREN] & wv[vcc_pkg::P_SWS]
                       & ~wv[vcc_pkg::P_MEAS];
            if (s_q.chan == vcc_pkg::CH_DIS &&
                (wv[vcc_pkg::P_MODE +: 2] != vcc_pkg::M_UNI1 ||
                 wv[vcc_pkg::P_STD2])) begin
              s_d.mode = vcc_pkg::vcc_mode_e'(wv[vcc_pkg::P_MODE +: 2]);
            end
          end
          vcc_pkg::OFS_FILT: s_d.k = wv[3:0];
          vcc_pkg::OFS_CBCMD: begin
            s_d.clo  = wv[vcc_pkg::P_LO +: 10];
            s_d.chi  = wv[vcc_pkg::P_HI +: 10];
            s_d.cset = 1'b1;
          end
          vcc_pkg::OFS_CBFB: begin
            s_d.flo  = wv[vcc_pkg::P_LO +: 10];
            s_d.fhi  = wv[vcc_pkg::P_HI +: 10];
            s_d.fset = 1'b1;
          end
          vcc_pkg::OFS_PRED: begin
            s_d.rms  = wv[15:0];
            s_d.rpct = (wv[vcc_pkg::P_RPCT +: 7] > 7'h64) ? 7'h64
                       : wv[vcc_pkg::P_RPCT +: 7];
          end
          vcc_pkg::OFS_DITH: begin
            s_d.damp = wv[7:0];
            s_d.dhlf = wv[vcc_pkg::P_DHLF +: 8];
          end
          default: s_d.ack = 1'b1;
        endcase
      end
    end
    if (sample_vld) begin
      s_d.fc = s_q.fc + 16'($signed(dc) >>> s_q.k);
      s_d.ff = s_q.ff + 16'($signed(df) >>> s_q.k);
    end
    if (!(cbok_c && brk_c)) begin
      s_d.cbc = '0;
      s_d.e1  = 1'b0;
    end else if (s_q.cbc == CBW'(CB_CYCLES - 1)) begin
      s_d.e1  = 1'b1;
    end else begin
      s_d.cbc = s_q.cbc + CBW'(1);
    end
    if (!(cbok_f && brk_f)) begin
      s_d.cbf = '0;
      s_d.e6  = 1'b0;
    end else if (s_q.cbf == CBW'(CB_CYCLES - 1)) begin
      s_d.e6  = 1'b1;
    end else begin
      s_d.cbf = s_q.cbf + CBW'(1);
    end
    s_d.cmd  = cmd_n;
    s_d.pcnt = tick ? '0 : s_q.pcnt + PW'(1);
    if (tick) begin
      s_d.duty = prod[25:10];
      s_d.dirb = s_q.cmd[10];
      s_d.dcnt = (s_q.dcnt >= s_q.dhlf) ? 8'h00 : s_q.dcnt + 8'h01;
      s_d.dph  = (s_q.dcnt >= s_q.dhlf) ? ~s_q.dph : s_q.dph;
    end
    // Timer restarts at once whenever the coil is off or the channel stops, and at the next PWM tick after the sign flips
    if (base == 10'h000 || s_q.chan != vcc_pkg::CH_ACT || react
        || (tick && s_q.dirb != s_q.cmd[10])) begin
      s_d.rcnt = 16'h0000;
      s_d.red  = 1'b0;
    end else if (tick && s_q.rcnt >= s_q.rms) begin
      s_d.red  = 1'b1;
    end else if (tick) begin
      s_d.rcnt = s_q.rcnt + 16'h0001;
    end
    s_d.pa = (s_q.pcnt < s_q.duty) && !s_q.dirb && (lvl != 10'h000);
    s_d.pb = (s_q.pcnt < s_q.duty) && s_q.dirb && (lvl != 10'h000);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.chan <= vcc_pkg::CH_DIS;
      s_q.mode <= vcc_pkg::M_UNI2;
      s_q.k    <= vcc_pkg::FILT_RST;
      s_q.rpct <= vcc_pkg::RPCT_RST;
      s_q.damp <= vcc_pkg::DAMP_RST;
      s_q.dhlf <= vcc_pkg::DHLF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seq_dis2;
    (s_q.chan == vcc_pkg::CH_DIS) [*2];
  endsequence
  sequence seq_wrap;
    s_q.pcnt == PW'(PWM_CYCLES - 1);
  endsequence

  AST_CB_DELAY: assert property ($rose(s_q.e1) |-> $past(s_q.cbc) == CBW'(CB_CYCLES - 1))
    else $error("Command break flagged early");
  AST_CB_GATE: assert property (s_q.e1 |-> $past(s_q.cben && s_q.cset
                                && s_q.sig <= vcc_pkg::SIG_MAXCB))
    else $error("Break flagged while check disabled");
  AST_CB_CLEAR: assert property (!brk_c |=> !s_q.e1)
    else $error("Break flag stuck inside limits");
  AST_NO_CUR: assert property (seq_dis2 |-> !pwm_a && !pwm_b)
    else $error("Solenoid driven while disabled");
  AST_MODE_LOCK: assert property (s_q.chan == vcc_pkg::CH_ACT |=> $stable(s_q.mode))
    else $error("Mode changed while active");
  AST_MODE1: assert property ($changed(s_q.mode) && s_q.mode == vcc_pkg::M_UNI1
                              |-> $past(wv[vcc_pkg::P_STD2]))
    else $error("Mode 1 without two-solenoid valve");
  AST_PR_GATE: assert property (s_q.pren |-> s_q.sws && !s_q.meas)
    else $error("Power reduction on wrong solenoid type");
  AST_PWM_WRAP: assert property (seq_wrap |=> s_q.pcnt == '0 ##1 s_q.pcnt == PW'(1))
    else $error("PWM period wrong");
  AST_MAP2: assert property (s_q.mode == vcc_pkg::M_UNI2 && $stable(s_q.mode)
                             |=> int'($signed(s_q.cmd)) == 2 * int'($past(xc)) - 1023)
    else $error("Mode 2 mapping wrong");
  AST_USB: assert property (usb_busy && s_q.mode == vcc_pkg::M_DIG |=> !s_q.cmd[10])
    else $error("Digital input used during USB");
endmodule
`default_nettype wire

// ### bench/vcc_partner.sv
`timescale 1ns/1ns
`default_nettype none
module vcc_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  cmd_val,
  input  wire logic [9:0]  fb_val,
  input  wire logic        pwm_a,
  input  wire logic        pwm_b,
  output logic             sample_vld,
  output logic [9:0]       ain_cmd,
  output logic [9:0]       ain_fb,
  output logic [10:0]      duty_a,
  output logic [10:0]      duty_b
);
  typedef struct packed {
    logic [9:0]  ph;
    logic [10:0] ca;
    logic [10:0] cb;
    logic        vld;
    logic [9:0]  cmd;
    logic [9:0]  fb;
    logic [10:0] da;
    logic [10:0] db;
  } vcc_ptn_s;
  vcc_ptn_s st_q;
  vcc_ptn_s st_d;
  always_comb begin
    st_d     = st_q;
    st_d.ph  = st_q.ph + 10'h001;
    // Converter delivers one sample every eight cycles
    st_d.vld = (st_q.ph[2:0] == 3'h0);
    st_d.cmd = cmd_val;
    st_d.fb  = fb_val;
    st_d.ca  = st_q.ca + {10'h000, pwm_a};
    st_d.cb  = st_q.cb + {10'h000, pwm_b};
    // Coil high time over one 1024-cycle window
    if (st_q.ph == 10'h3FF) begin
      st_d.da = st_d.ca;
      st_d.db = st_d.cb;
      st_d.ca = '0;
      st_d.cb = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sample_vld = st_q.vld;
  assign ain_cmd    = st_q.cmd;
  assign ain_fb     = st_q.fb;
  assign duty_a     = st_q.da;
  assign duty_b     = st_q.db;
endmodule
`default_nettype wire

// ### bench/vcc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module vcc_top_tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic [7:0]  avs_address = '0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  logic        sample_vld;
  logic [9:0]  ain_cmd;
  logic [9:0]  ain_fb;
  logic [9:0]  cmd_val = '0;
  logic [9:0]  fb_val = '0;
  logic        din1 = 0;
  logic        usb_busy = 0;
  logic        pwm_a;
  logic        pwm_b;
  logic        meas_en;
  logic        cmd_fault;
  logic        fb_fault;
  logic        fault_react;
  logic        chan_active;
  logic [10:0] cmd_int;
  logic [10:0] duty_a;
  logic [10:0] duty_b;
  int          failures = 0;
  int          samples_checked = 0;

  vcc_top #(.CB_CYCLES(20), .PWM_CYCLES(1024)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .sample_vld(sample_vld), .ain_cmd(ain_cmd), .ain_fb(ain_fb), .din1(din1),
    .usb_busy(usb_busy), .pwm_a(pwm_a), .pwm_b(pwm_b), .meas_en(meas_en),
    .cmd_fault(cmd_fault), .fb_fault(fb_fault), .fault_react(fault_react),
    .chan_active(chan_active), .cmd_int(cmd_int));

  vcc_partner ptn_u (
    .clk(clk), .rst(sys_rst), .cmd_val(cmd_val), .fb_val(fb_val), .pwm_a(pwm_a),
    .pwm_b(pwm_b), .sample_vld(sample_vld), .ain_cmd(ain_cmd), .ain_fb(ain_fb),
    .duty_a(duty_a), .duty_b(duty_b));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk("register", q, e);
  endtask

  // Waits until a fresh sample has passed filter and mapping
  task automatic settle();
    repeat (2) @(posedge clk);
    do begin
      @(posedge clk);
    end while (sample_vld !== 1'b1);
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_map(input logic [1:0] m, input logic s, input logic [9:0] x,
                       input logic d, input logic u, input logic [10:0] e);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0000);
    wr(vcc_pkg::OFS_CTRL, {28'h000_0000, s, m, 1'b1});
    cmd_val  <= x;
    din1     <= d;
    usb_busy <= u;
    settle();
    chk("cmd_int", {21'h0, cmd_int}, {21'h0, e});
  endtask

  task automatic t_reset();
    rc(vcc_pkg::OFS_CTRL, 32'h0000_0002);
    rc(vcc_pkg::OFS_FILT, 32'h0000_0004);
    rc(vcc_pkg::OFS_DITH, 32'h0000_0510);
    rc(vcc_pkg::OFS_STAT, 32'h0000_0000);
    rc(8'h40, 32'h0000_0000);
  endtask

  task automatic t_filter();
    wr(vcc_pkg::OFS_FILT, 32'h0000_0001);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0009);
    cmd_val <= 10'h200;
    settle();
    chk("cmd_int", {21'h0, cmd_int}, 32'h0000_0100);
    settle();
    chk("cmd_int", {21'h0, cmd_int}, 32'h0000_0180);
    wr(vcc_pkg::OFS_FILT, 32'h0000_0000);
  endtask

  task automatic t_modes();
    t_map(2'h0, 1'b1, 10'h12C, 1'b0, 1'b0, 11'h12C);
    t_map(2'h1, 1'b0, 10'h064, 1'b0, 1'b0, 11'h4C9);
    t_map(2'h2, 1'b0, 10'h3C0, 1'b0, 1'b0, 11'h780);
    t_map(2'h2, 1'b0, 10'h200, 1'b0, 1'b0, 11'h401);
    t_map(2'h3, 1'b0, 10'h190, 1'b0, 1'b0, 11'h190);
    t_map(2'h3, 1'b0, 10'h190, 1'b1, 1'b0, 11'h670);
    t_map(2'h3, 1'b0, 10'h190, 1'b1, 1'b1, 11'h190);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0009);
    rc(vcc_pkg::OFS_CTRL, 32'h0000_000F);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0000);
    rc(vcc_pkg::OFS_CTRL, 32'h0000_0006);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0000);
    rc(vcc_pkg::OFS_CTRL, 32'h0000_0006);
  endtask

  task automatic t_pwm();
    wr(vcc_pkg::OFS_DITH, 32'h0000_0000);
    t_map(2'h0, 1'b1, 10'h200, 1'b0, 1'b0, 11'h200);
    repeat (3100) @(posedge clk);
    chk("duty_a", {21'h0, duty_a}, 32'h0000_0200);
    chk("duty_b", {21'h0, duty_b}, 32'h0000_0000);
    t_map(2'h1, 1'b0, 10'h000, 1'b0, 1'b0, 11'h401);
    repeat (3100) @(posedge clk);
    chk("duty_b", {21'h0, duty_b}, 32'h0000_03FF);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0022);
    @(negedge clk);
    chk("meas_en", {31'h0, meas_en}, 32'h0000_0001);
    chk("chan_active", {31'h0, chan_active}, 32'h0000_0000);
    repeat (3100) @(posedge clk);
    chk("duty_b", {21'h0, duty_b}, 32'h0000_0000);
  endtask

  task automatic t_cb();
    wr(vcc_pkg::OFS_CBCMD, 32'h0384_0064);
    wr(vcc_pkg::OFS_CBFB, 32'h0384_0064);
    cmd_val <= 10'h032;
    fb_val  <= 10'h1F4;
    t_map(2'h0, 1'b1, 10'h032, 1'b0, 1'b0, 11'h032);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0019);
    settle();
    chk("cmd_fault", {31'h0, cmd_fault}, 32'h0000_0000);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk("cmd_fault", {31'h0, cmd_fault}, 32'h0000_0001);
    chk("fault_react", {31'h0, fault_react}, 32'h0000_0000);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0119);
    cmd_val <= 10'h1F4;
    fb_val  <= 10'h3B6;
    @(negedge clk);
    chk("fault_react", {31'h0, fault_react}, 32'h0000_0001);
    chk("chan_active", {31'h0, chan_active}, 32'h0000_0001);
    repeat (40) @(posedge clk);
    cmd_val <= 10'h032;
    fb_val  <= 10'h1F4;
    @(negedge clk);
    chk("cmd_fault", {31'h0, cmd_fault}, 32'h0000_0000);
    chk("fb_fault", {31'h0, fb_fault}, 32'h0000_0001);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0919);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk("cmd_fault", {31'h0, cmd_fault}, 32'h0000_0000);
  endtask

  task automatic t_pred();
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0000);
    wr(vcc_pkg::OFS_PRED, 32'h0032_0002);
    cmd_val <= 10'h3FF;
    wr(vcc_pkg::OFS_CTRL, 32'h0000_00C9);
    rc(vcc_pkg::OFS_CTRL, 32'h0000_00C9);
    rc(vcc_pkg::OFS_STAT, 32'h0000_0018);
    repeat (8000) @(posedge clk);
    chk("duty_a", {21'h0, duty_a}, 32'h0000_01FF);
    rc(vcc_pkg::OFS_STAT, 32'h0000_0038);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_0000);
    wr(vcc_pkg::OFS_CTRL, 32'h0000_00E8);
    rc(vcc_pkg::OFS_CTRL, 32'h0000_0068);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    t_reset();
    t_filter();
    t_modes();
    t_pwm();
    t_cb();
    t_pred();
    finish_test();
  end

  initial begin
    #(100 * 60000);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
